// ==== fpac_defs.svh ====
`ifndef FPAC_DEFS_SVH
`define FPAC_DEFS_SVH

// indexed i/o port
`define FPAC_PORT_INDEX    16'h03ce
`define FPAC_PORT_DATA     16'h03cf
`define FPAC_IDX_COL_OFS   8'hd0
`define FPAC_IDX_OVERFLOW  8'hd4
`define FPAC_IDX_ATTR      8'hd5

// attribute control fields
`define FPAC_BIT_AUTO_MAP  7
`define FPAC_BIT_TEXT_REV  6
`define FPAC_BIT_GFX_REV   5
`define FPAC_BIT_XLINE     4
`define FPAC_BIT_EMUL      3
`define FPAC_BIT_STANDBY   2
`define FPAC_BIT_COMP_HI   1
`define FPAC_BIT_COMP_LO   0
`define FPAC_BIT_COL_MSB   0
`define FPAC_ATTR_RESET    8'h00
`define FPAC_ATTR_WMASK    8'hfb
`define FPAC_OVF_MASK      8'h7f

// text geometry
`define FPAC_PANEL_WIDTH   10'h280
`define FPAC_COL_CENTER    9'h00a
`define FPAC_DOT_EIGHTH    4'h7
`define FPAC_DOT_NINTH     4'h8
`define FPAC_GRAY_MAX      6'h3f

`endif

// ==== fpac_pkg.sv ====
package fpac_pkg;

  // per-line panel window state, gray coded along idle-pad-pass-done
  typedef enum logic [1:0] {
    FPAC_IDLE = 2'b00,
    FPAC_PAD  = 2'b01,
    FPAC_PASS = 2'b11,
    FPAC_DONE = 2'b10
  } fpac_line_t;

  // one pixel moving down the panel path
  typedef struct packed {
    logic       valid;
    logic       blank;
    logic       text;
    logic       fg;
    logic       fg_wins;
    logic [7:0] idx;
  } fpac_pix_t;

  // complete module state
  typedef struct packed {
    logic [7:0] index_reg;
    logic [7:0] attr_reg;
    logic [7:0] col_lo_reg;
    logic [7:0] ovf_reg;
    logic [7:0] rdata_reg;
    logic       sb_meta_reg;
    logic       sb_sync_reg;
    fpac_line_t line_reg;
    logic [9:0] pad_reg;
    logic [9:0] skip_reg;
    logic [9:0] out_cnt_reg;
    logic [7:0] held_idx_reg;
    logic       held_fg_reg;
    fpac_pix_t  s1_reg;
    logic [5:0] gray_reg;
    logic       gray_valid_reg;
    logic [7:0] crt_idx_reg;
    logic       crt_valid_reg;
    logic       lclk_up_reg;
    logic       lclk_lo_reg;
    logic       extra_reg;
  } fpac_state_t;

endpackage : fpac_pkg

// ==== fpac_gray_map.sv ====
`timescale 1ns/10ps
`include "fpac_defs.svh"

module fpac_gray_map #(
  parameter int DEPTH = 256
) (
  input  wire logic        clk,
  input  wire logic        wr,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [17:0] wr_rgb,
  input  wire logic [7:0]  rd_addr,
  output logic      [5:0]  rd_gray
);

  logic [5:0] mem [DEPTH];
  logic [9:0] sum;

  // weighted sum of 6-bit r, g, b; weights 5+9+2 = 16 keep the result in 6 bits
  always_comb begin
    sum = 10'(wr_rgb[17:12]) * 10'h005 + 10'(wr_rgb[11:6]) * 10'h009 + 10'(wr_rgb[5:0]) * 10'h002;
  end

  // palette shadow of the colour lookup, read one cycle late
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[wr_addr] <= sum[9:4];
    end
    rd_gray <= mem[rd_addr];
  end

endmodule : fpac_gray_map

// ==== fpac_attr_ctrl.sv ====
`timescale 1ns/10ps
`include "fpac_defs.svh"

module fpac_attr_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic        standby_pin,
  input  wire logic        pal_wr,
  input  wire logic [7:0]  pal_addr,
  input  wire logic [17:0] pal_rgb,
  input  wire logic        line_start,
  input  wire logic        text_mode,
  input  wire logic        pix_valid,
  output logic             pix_ready,
  input  wire logic [7:0]  pix_index,
  input  wire logic [3:0]  pix_dot,
  input  wire logic        pix_fg,
  input  wire logic [3:0]  attr_fg,
  input  wire logic [3:0]  attr_bg,
  input  wire logic        line_pulse,
  input  wire logic        lower_start,
  input  wire logic        dual_scan,
  output logic      [5:0]  panel_gray,
  output logic             panel_valid,
  output logic             panel_lclk_upper,
  output logic             panel_lclk_lower,
  output logic      [7:0]  crt_index,
  output logic             crt_valid
);

  fpac_pkg::fpac_state_t st_reg;
  fpac_pkg::fpac_state_t st_next;
  fpac_pkg::fpac_pix_t   emit;
  logic       [8:0]      col_ofs;
  logic       [1:0]      comp;
  logic                  accept;
  logic                  data_port;
  logic       [5:0]      pal_gray;
  logic       [5:0]      base_gray;
  logic                  reverse;

  // shadow palette lookup, aligned with the stage-one pixel
  fpac_gray_map #(
    .DEPTH (256)
  ) u_gray_map (
    .clk     (clk),
    .wr      (pal_wr),
    .wr_addr (pal_addr),
    .wr_rgb  (pal_rgb),
    .rd_addr (emit.idx),
    .rd_gray (pal_gray)
  );

  assign col_ofs   = {st_reg.ovf_reg[`FPAC_BIT_COL_MSB], st_reg.col_lo_reg};
  assign comp      = st_reg.attr_reg[`FPAC_BIT_COMP_HI:`FPAC_BIT_COMP_LO];
  assign data_port = (io_addr == `FPAC_PORT_DATA);
  // padding stalls the source rather than buffering up to ten pixels
  assign pix_ready = (st_reg.line_reg != fpac_pkg::FPAC_PAD);
  assign accept    = pix_valid & pix_ready;

  // selection of what the panel shows from the accepted pixel
  always_comb begin
    emit         = '0;
    emit.text    = text_mode;
    emit.fg      = pix_fg;
    emit.idx     = pix_index;
    emit.fg_wins = (attr_fg >= attr_bg);
    if (st_reg.line_reg == fpac_pkg::FPAC_PAD) begin
      emit.valid = 1'b1;
      emit.blank = 1'b1;
    end else if (accept && (st_reg.line_reg != fpac_pkg::FPAC_DONE)) begin
      if (!text_mode) begin
        emit.valid = 1'b1;
      end else if (!comp[1]) begin
        emit.valid = (st_reg.skip_reg == 10'h000);
      end else if (!comp[0]) begin
        emit.valid = (pix_dot != `FPAC_DOT_NINTH);
      end else if (pix_dot == `FPAC_DOT_NINTH) begin
        emit.valid = 1'b1;
        emit.idx   = st_reg.held_idx_reg | pix_index;
        emit.fg    = st_reg.held_fg_reg | pix_fg;
      end else begin
        emit.valid = (pix_dot != `FPAC_DOT_EIGHTH);
      end
    end
  end

  // panel gray before reverse video
  always_comb begin
    base_gray = pal_gray;
    if (st_reg.s1_reg.text && st_reg.attr_reg[`FPAC_BIT_EMUL]) begin
      base_gray = (st_reg.s1_reg.fg == st_reg.s1_reg.fg_wins) ? `FPAC_GRAY_MAX : 6'h00;
    end else if (!st_reg.attr_reg[`FPAC_BIT_AUTO_MAP]) begin
      base_gray = st_reg.s1_reg.idx[7:2];
    end
    reverse = st_reg.s1_reg.text ? st_reg.attr_reg[`FPAC_BIT_TEXT_REV]
                                 : st_reg.attr_reg[`FPAC_BIT_GFX_REV];
  end

  // next state of everything
  always_comb begin
    st_next = st_reg;

    // register port: index at 3ce, data at 3cf
    if (io_wr && (io_addr == `FPAC_PORT_INDEX)) begin
      st_next.index_reg = io_wdata;
    end
    if (io_wr && data_port) begin
      case (st_reg.index_reg)
        `FPAC_IDX_ATTR:     st_next.attr_reg   = io_wdata & `FPAC_ATTR_WMASK;
        `FPAC_IDX_COL_OFS:  st_next.col_lo_reg = io_wdata;
        `FPAC_IDX_OVERFLOW: st_next.ovf_reg    = io_wdata & `FPAC_OVF_MASK;
        default:            st_next.ovf_reg    = st_reg.ovf_reg;
      endcase
    end
    if (io_rd) begin
      if (io_addr == `FPAC_PORT_INDEX) begin
        st_next.rdata_reg = st_reg.index_reg;
      end else if (data_port) begin
        case (st_reg.index_reg)
          `FPAC_IDX_ATTR:     st_next.rdata_reg = st_reg.attr_reg |
                                                  {5'h00, st_reg.sb_sync_reg, 2'h0};
          `FPAC_IDX_COL_OFS:  st_next.rdata_reg = st_reg.col_lo_reg;
          `FPAC_IDX_OVERFLOW: st_next.rdata_reg = st_reg.ovf_reg;
          default:            st_next.rdata_reg = 8'h00;
        endcase
      end else begin
        st_next.rdata_reg = 8'h00;
      end
    end

    // standby pin is asynchronous to clk
    st_next.sb_meta_reg = standby_pin;
    st_next.sb_sync_reg = st_reg.sb_meta_reg;

    // crt sees every accepted pixel untouched
    st_next.crt_valid_reg = accept;
    if (accept) begin
      st_next.crt_idx_reg = pix_index;
    end

    // hold eighth dot for the or-merge
    if (accept && (pix_dot == `FPAC_DOT_EIGHTH)) begin
      st_next.held_idx_reg = pix_index;
      st_next.held_fg_reg  = pix_fg;
    end

    // panel line window
    case (st_reg.line_reg)
      fpac_pkg::FPAC_IDLE,
      fpac_pkg::FPAC_DONE: begin
        st_next.line_reg = st_reg.line_reg;
      end
      fpac_pkg::FPAC_PAD: begin
        st_next.pad_reg = st_reg.pad_reg - 10'h001;
        if (st_reg.pad_reg == 10'h001) begin
          st_next.line_reg = fpac_pkg::FPAC_PASS;
        end
      end
      fpac_pkg::FPAC_PASS: begin
        if (accept && text_mode && !comp[1] && (st_reg.skip_reg != 10'h000)) begin
          st_next.skip_reg = st_reg.skip_reg - 10'h001;
        end
      end
      default: begin
        st_next.line_reg = fpac_pkg::FPAC_IDLE;
      end
    endcase
    if (emit.valid && emit.text) begin
      st_next.out_cnt_reg = st_reg.out_cnt_reg + 10'h001;
      if (st_reg.out_cnt_reg == `FPAC_PANEL_WIDTH - 10'h001) begin
        st_next.line_reg = fpac_pkg::FPAC_DONE;
      end
    end
    // new line restarts the window; padding and skipping only for the windowed text mode
    if (line_start) begin
      st_next.out_cnt_reg = 10'h000;
      st_next.pad_reg     = 10'h000;
      st_next.skip_reg    = 10'h000;
      st_next.line_reg    = fpac_pkg::FPAC_PASS;
      if (text_mode && !comp[1]) begin
        if (col_ofs < `FPAC_COL_CENTER) begin
          st_next.pad_reg  = {1'b0, `FPAC_COL_CENTER - col_ofs};
          st_next.line_reg = fpac_pkg::FPAC_PAD;
        end else begin
          st_next.skip_reg = {1'b0, col_ofs - `FPAC_COL_CENTER};
        end
      end
    end

    // stage one then gray stage
    st_next.s1_reg         = emit;
    st_next.gray_valid_reg = st_reg.s1_reg.valid;
    if (st_reg.s1_reg.blank) begin
      st_next.gray_reg = 6'h00; // padding stays dark, reverse or not
    end else begin
      st_next.gray_reg = reverse ? ~base_gray : base_gray;
    end

    // line clocks; extra pulse lands two cycles after the lower half starts
    st_next.extra_reg   = lower_start & dual_scan & st_reg.attr_reg[`FPAC_BIT_XLINE];
    st_next.lclk_up_reg = line_pulse;
    st_next.lclk_lo_reg = line_pulse | st_reg.extra_reg;
  end

  // single state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign io_rdata         = st_reg.rdata_reg;
  assign panel_gray       = st_reg.gray_reg;
  assign panel_valid      = st_reg.gray_valid_reg;
  assign panel_lclk_upper = st_reg.lclk_up_reg;
  assign panel_lclk_lower = st_reg.lclk_lo_reg;
  assign crt_index        = st_reg.crt_idx_reg;
  assign crt_valid        = st_reg.crt_valid_reg;

  // checks on the live design
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  attr_write_a: assert property ((io_wr && data_port && st_reg.index_reg == `FPAC_IDX_ATTR)
    |=> st_reg.attr_reg == ($past(io_wdata) & `FPAC_ATTR_WMASK)) else $error("attr write wrong");
  standby_read_a: assert property ((io_rd && data_port && st_reg.index_reg == `FPAC_IDX_ATTR)
    |=> io_rdata[`FPAC_BIT_STANDBY] == $past(st_reg.sb_sync_reg)) else $error("standby bit wrong");
  ninth_drop_a: assert property ((accept && text_mode && comp == 2'b10 && pix_dot == `FPAC_DOT_NINTH
    && !line_start) |-> ##2 !panel_valid) else $error("ninth dot shown");
  eighth_hold_a: assert property ((accept && text_mode && comp == 2'b11 && pix_dot == `FPAC_DOT_EIGHTH
    && st_reg.line_reg == fpac_pkg::FPAC_PASS) |-> ##2 !panel_valid) else $error("eighth dot shown");
  pad_stall_a: assert property ((line_start && text_mode && !comp[1] && col_ofs < `FPAC_COL_CENTER)
    |=> !pix_ready [*1] ##0 (st_reg.pad_reg == {1'b0, `FPAC_COL_CENTER - $past(col_ofs)}))
    else $error("pad not started");
  extra_pulse_a: assert property ((lower_start && dual_scan && st_reg.attr_reg[`FPAC_BIT_XLINE])
    |-> ##2 panel_lclk_lower) else $error("extra line pulse missing");
  no_extra_a: assert property ((!line_pulse && !st_reg.extra_reg) |=> !panel_lclk_lower)
    else $error("spurious lower line pulse");
  crt_pass_a: assert property (accept |=> crt_valid && crt_index == $past(pix_index))
    else $error("crt stream altered");
  width_cap_a: assert property (st_reg.out_cnt_reg <= `FPAC_PANEL_WIDTH)
    else $error("more than panel width");
  emul_gray_a: assert property ((st_reg.s1_reg.valid && !st_reg.s1_reg.blank && st_reg.s1_reg.text
    && st_reg.attr_reg[`FPAC_BIT_EMUL] && !$changed(st_reg.attr_reg))
    |=> panel_gray == 6'h00 || panel_gray == `FPAC_GRAY_MAX) else $error("emulation gray not extreme");

  squeeze_c: cover property (accept && text_mode && comp == 2'b10 && pix_dot == `FPAC_DOT_NINTH);
  merge_c: cover property (accept && text_mode && comp == 2'b11 && pix_dot == `FPAC_DOT_NINTH);
  pad_c: cover property (st_reg.line_reg == fpac_pkg::FPAC_PAD ##1 st_reg.line_reg == fpac_pkg::FPAC_PASS);
  extra_c: cover property (st_reg.extra_reg ##1 panel_lclk_lower);

endmodule : fpac_attr_ctrl

// ==== fpac_panel_model.sv ====
`timescale 1ns/10ps

module fpac_panel_model (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [5:0] gray,
  input wire logic       valid,
  input wire logic       lclk_upper,
  input wire logic       lclk_lower
);
  logic [5:0] seen_q[$];
  int         upper_cnt;
  int         lower_cnt;

  // glass side: latch each pixel and line clock; unknown strobes are not counted
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_cnt <= 0;
      lower_cnt <= 0;
    end else begin
      if (valid === 1'b1) seen_q.push_back(gray);
      if (lclk_upper === 1'b1) upper_cnt <= upper_cnt + 1;
      if (lclk_lower === 1'b1) lower_cnt <= lower_cnt + 1;
    end
  end
endmodule : fpac_panel_model

// ==== fpac_attr_ctrl_test.sv ====
`timescale 1ns/10ps
`include "fpac_defs.svh"

module fpac_attr_ctrl_test;
  logic clk = 0, rst_n = 0, io_wr = 0, io_rd = 0, standby_pin = 0, pal_wr = 0;
  logic line_start = 0, text_mode = 0, pix_valid = 0, pix_fg = 0, line_pulse = 0;
  logic lower_start = 0, dual_scan = 0, pix_ready, panel_valid, lclk_u, lclk_l, crt_valid;
  logic [15:0] io_addr = 0;
  logic [7:0]  io_wdata = 0, pal_addr = 0, pix_index = 0, io_rdata, crt_index, v, crt_last;
  logic [17:0] pal_rgb = 0;
  logic [3:0]  pix_dot = 0, attr_fg = 0, attr_bg = 0;
  logic [5:0]  panel_gray, pal[256];
  int          failures = 0, checked = 0, crt_cnt = 0, l0;

  always #4 clk = ~clk;

  fpac_attr_ctrl dut (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .standby_pin(standby_pin), .pal_wr(pal_wr),
    .pal_addr(pal_addr), .pal_rgb(pal_rgb), .line_start(line_start), .text_mode(text_mode),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_index(pix_index), .pix_dot(pix_dot),
    .pix_fg(pix_fg), .attr_fg(attr_fg), .attr_bg(attr_bg), .line_pulse(line_pulse),
    .lower_start(lower_start), .dual_scan(dual_scan), .panel_gray(panel_gray),
    .panel_valid(panel_valid), .panel_lclk_upper(lclk_u), .panel_lclk_lower(lclk_l),
    .crt_index(crt_index), .crt_valid(crt_valid));

  fpac_panel_model panel (.clk(clk), .rst_n(rst_n), .gray(panel_gray), .valid(panel_valid),
    .lclk_upper(lclk_u), .lclk_lower(lclk_l));

  // crt copy counter, kept apart from the panel path on purpose
  always @(posedge clk) begin
    if (crt_valid === 1'b1) begin
      crt_cnt <= crt_cnt + 1;
      crt_last <= crt_index;
    end
  end

  task automatic tally_and_finish();
    $display("counts: %0d checked, %0d failures", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // index write then data write; one idle edge keeps io_wr from toggling twice
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    io_addr = `FPAC_PORT_INDEX;
    io_wdata = i;
    io_wr = 1;
    @(negedge clk);
    io_addr = `FPAC_PORT_DATA;
    io_wdata = d;
    @(negedge clk);
    io_wr = 0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] i, output logic [7:0] d);
    io_addr = `FPAC_PORT_INDEX;
    io_wdata = i;
    io_wr = 1;
    @(negedge clk);
    io_wr = 0;
    io_rd = 1;
    io_addr = `FPAC_PORT_DATA;
    @(negedge clk);
    io_rd = 0;
    @(negedge clk);
    d = io_rdata;
  endtask : rd

  // offer one pixel, hold it through the pad stall; valid stays high for back-to-back
  task automatic pix(input logic [7:0] i, input logic [3:0] d, input logic f);
    int n;
    pix_valid = 1;
    pix_index = i;
    pix_dot = d;
    pix_fg = f;
    n = 0;
    while (pix_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n == 50) begin
      failures++;
      tally_and_finish();
    end
    @(negedge clk);
  endtask : pix

  function automatic logic [5:0] gexp(logic [7:0] a, logic [7:0] i, logic f, logic t);
    logic [5:0] g;
    if (t && a[3]) g = (f == (attr_fg >= attr_bg)) ? 6'h3f : 6'h00;
    else g = a[7] ? pal[i] : i[7:2];
    if ((t && a[6]) || (!t && a[5])) g = ~g;
    return g;
  endfunction : gexp

  // one nine-dot cell per line; expectation built dot by dot
  task automatic run_line(input logic [7:0] a, input logic t, input int off);
    logic [7:0] ix[9];
    logic       fx[9];
    logic [5:0] e[$];
    int         k;
    int         c0;
    wr(`FPAC_IDX_ATTR, a);
    wr(`FPAC_IDX_COL_OFS, 8'(off));
    wr(`FPAC_IDX_OVERFLOW, 8'(off >> 8));
    text_mode = t;
    attr_fg = 4'($urandom);
    attr_bg = 4'($urandom);
    for (k = 0; k < 9; k++) begin
      ix[k] = 8'($urandom);
      fx[k] = 1'($urandom);
    end
    if (t && !a[1]) for (k = 0; k < 10 - off; k++) e.push_back(6'h00);
    for (k = 0; k < 9; k++) begin
      if (t && !a[1] && k < off - 10) continue;
      if (t && a[1:0] == 2'h2 && k == 8) continue;
      if (t && a[1:0] == 2'h3 && k == 7) continue;
      if (t && a[1:0] == 2'h3 && k == 8) e.push_back(gexp(a, ix[7] | ix[8], fx[7] | fx[8], t));
      else e.push_back(gexp(a, ix[k], fx[k], t));
    end
    panel.seen_q.delete();
    c0 = crt_cnt;
    line_start = 1;
    @(negedge clk);
    line_start = 0;
    for (k = 0; k < 9; k++) pix(ix[k], 4'(k), fx[k]);
    pix_valid = 0;
    repeat (4) @(negedge clk);
    check("panel count", panel.seen_q.size(), e.size());
    for (k = 0; k < e.size() && k < panel.seen_q.size(); k++)
      check("panel gray", panel.seen_q[k], e[k]);
    check("crt count", crt_cnt - c0, 9);
    check("crt index", crt_last, ix[8]);
  endtask : run_line

  // attribute setting, text flag, column offset for each line
  // last line needs the offset top bit: without it the low byte alone would show all nine dots
  logic [7:0] cfg_a[14] = '{8'h00, 8'h20, 8'h80, 8'ha0, 8'h40, 8'h00, 8'h01, 8'h02, 8'h03,
                            8'h40, 8'h08, 8'h48, 8'ha2, 8'h00};
  logic       cfg_t[14] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1};
  int         cfg_o[14] = '{10, 10, 10, 10, 10, 7, 12, 10, 10, 10, 10, 10, 10, 266};

  initial begin
    void'($urandom(79));
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    rd(`FPAC_IDX_ATTR, v);
    check("attr reset", v, `FPAC_ATTR_RESET);
    wr(`FPAC_IDX_ATTR, 8'hff);
    rd(`FPAC_IDX_ATTR, v);
    check("attr write", v, 8'hfb);
    standby_pin = 1;
    repeat (4) @(negedge clk);
    rd(`FPAC_IDX_ATTR, v);
    check("standby set", v, 8'hff);
    standby_pin = 0;
    wr(`FPAC_IDX_OVERFLOW, 8'hff);
    rd(`FPAC_IDX_OVERFLOW, v);
    check("overflow", v, `FPAC_OVF_MASK);
    wr(`FPAC_IDX_OVERFLOW, 8'h00);
    wr(8'hd7, 8'h55);
    rd(8'hd7, v);
    check("unmapped", v, 8'h00);
    $display("test registers done");
    // shadow palette with random colours, gray worked out here
    for (int a = 0; a < 256; a++) begin
      pal_rgb = 18'($urandom);
      pal_addr = 8'(a);
      pal[a] = 6'((5 * pal_rgb[17:12] + 9 * pal_rgb[11:6] + 2 * pal_rgb[5:0]) >> 4);
      pal_wr = 1;
      @(negedge clk);
    end
    pal_wr = 0;
    for (int n = 0; n < 14; n++) run_line(cfg_a[n], cfg_t[n], cfg_o[n]);
    $display("test pixel path done");
    dual_scan = 1;
    for (int en = 1; en >= 0; en--) begin
      wr(`FPAC_IDX_ATTR, en ? 8'h10 : 8'h00);
      l0 = panel.lower_cnt;
      lower_start = 1;
      @(negedge clk);
      lower_start = 0;
      repeat (4) @(negedge clk);
      check("extra pulse", panel.lower_cnt - l0, en);
    end
    l0 = panel.upper_cnt;
    line_pulse = 1;
    @(negedge clk);
    line_pulse = 0;
    repeat (4) @(negedge clk);
    check("upper pulse", panel.upper_cnt - l0, 1);
    $display("test line clocks done");
    tally_and_finish();
  end
endmodule : fpac_attr_ctrl_test
